// >>> rtl/ddr_init_defines.svh
// Offsets, field positions, reset values and cycle counts of the DDR SDRAM command block.
`ifndef DDR_INIT_DEFINES_SVH
`define DDR_INIT_DEFINES_SVH

`define REG_CONFIG 4'h0
`define REG_MODE 4'h4
`define REG_EXT 4'h8
`define REG_STATUS 4'hC

`define CFG_WIDE16_RST 1'b1
`define MODE_RST 13'h0021
`define EXT_RST 13'h0001

`define F_BT 3
`define F_DLL_RST 8
`define F_EXT_DLL_DIS 0
`define F_AP 10
`define ST_LOAD_ERR 9
`define ST_BL_ERR 10

`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define CL_CODE_25 3'h6
`define CL_CODE_3 3'h3

`define CL2_HALF 3'h4
`define CL25_HALF 3'h5
`define CL3_HALF 3'h6
`define WR_LAT_HALF 3'h2

`define LOAD_GAP_CK 2'h1
`define DLL_LOCK_CK 8'hC8
`define REFRESH_MIN 2'h2

`endif

// >>> rtl/ddr_mode_pkg.sv
// Types shared by the DDR SDRAM command block and its burst order generator.
package ddr_mode_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_LOAD,
    CMD_REFRESH,
    CMD_PRECHARGE,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_READ
  } cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE
  } phase_t;

  typedef enum logic [1:0] {
    BL_TWO,
    BL_FOUR,
    BL_EIGHT
  } blen_t;

endpackage

// >>> rtl/burst_if.sv
// Interface between the command block and the burst column order generator.
`timescale 1ns/1ps
`default_nettype none
interface burst_if;
  logic [9:0] start;
  logic [2:0] beat;
  ddr_mode_pkg::blen_t bl;
  logic interleave;
  logic [9:0] col;

  modport gen (input start, input beat, input bl, input interleave, output col);
  modport user (output start, output beat, output bl, output interleave, input col);
endinterface
`default_nettype wire

// >>> rtl/ddr_burst_order.sv
// Column order generator for sequential and interleaved bursts.
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_order (
  // Burst request and resulting column.
  burst_if.gen bif
);

  // Upper column bits pick the block; only the low bits move, so the burst wraps.
  function automatic logic [9:0] order_col(input logic [9:0] start, input logic [2:0] beat,
                                           input ddr_mode_pkg::blen_t bl, input logic ileave);
    logic [2:0] span;
    logic [2:0] off;
    span = (bl == ddr_mode_pkg::BL_TWO) ? 3'h1 : (bl == ddr_mode_pkg::BL_FOUR) ? 3'h3 : 3'h7;
    off = ileave ? (start[2:0] ^ beat) : (start[2:0] + beat);
    order_col = {start[9:3], (start[2:0] & ~span) | (off & span)};
  endfunction

  // The column is a pure function of the burst state held by the caller.
  assign bif.col = order_col(bif.start, bif.beat, bif.bl, bif.interleave);

endmodule
`default_nettype wire

// >>> rtl/ddr_sdram_init_mode_burst.sv
// DDR SDRAM device side: command decode, mode registers, bursts, masking, register slave.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_init_defines.svh"
module ddr_sdram_init_mode_burst (
  // System clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Command and address pins from the controller.
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic [12:0] A,
  // Data, mask and strobe pins.
  input wire logic [1:0] DM,
  input wire logic [15:0] DQ_IN,
  output logic [15:0] DQ_OUT,
  output logic [15:0] DQ_OE,
  output logic [1:0] DQS_OUT,
  output logic [1:0] DQS_OE,
  // Avalon-MM register slave.
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  logic [38:0] pin_raw;
  logic [38:0] pin_s1;
  logic [38:0] pin_s2;
  logic ck_prev;
  logic ck_s;
  logic cke_s;
  logic [3:0] strobes_s;
  logic [1:0] ba_s;
  logic [12:0] a_s;
  logic [1:0] dm_s;
  logic [15:0] dq_s;
  logic ck_rise;
  logic edge_any;
  logic cke_prev;
  logic cke_seen;
  ddr_mode_pkg::cmd_t cmd;
  logic issue;
  logic accept;
  logic in_load;
  logic is_load_mode;
  logic is_load_ext;
  logic bl_legal;
  logic start_burst;
  logic close_one;
  logic refresh_ok;
  logic [3:0] open_banks;
  logic [12:0] mode_reg;
  logic [12:0] ext_reg;
  logic [1:0] busy;
  logic load_err;
  logic bl_err;
  logic [7:0] lock_cnt;
  logic [1:0] ref_cnt;
  logic ready;
  logic wide16;
  logic dll_en;
  logic dll_locked;
  ddr_mode_pkg::phase_t phase;
  logic [2:0] hold_cnt;
  logic [2:0] lat_r;
  logic [2:0] lat_sel;
  logic [2:0] beat;
  logic [2:0] last_beat;
  logic [9:0] start_col;
  logic [1:0] bank_r;
  logic emit;
  logic rd_emit;
  logic wr_emit;
  logic we_lo;
  logic we_hi;
  logic [5:0] idx;
  logic [15:0] mem [0:63];
  logic [2:0] edge_cnt;
  logic bus_take;
  logic [1:0] st_clr;
  logic next_load_err;
  logic next_bl_err;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  burst_if bif ();

  // Pin order of the synchroniser vector; the last stage alone feeds the logic.
  assign pin_raw = {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A, DM, DQ_IN};
  assign ck_s = pin_s2[38];
  assign cke_s = pin_s2[37];
  assign strobes_s = pin_s2[36:33];
  assign ba_s = pin_s2[32:31];
  assign a_s = pin_s2[30:18];
  assign dm_s = pin_s2[17:16];
  assign dq_s = pin_s2[15:0];
  assign ck_rise = ck_s & ~ck_prev;
  assign edge_any = ck_s ^ ck_prev;

  // Every pin crosses two flip-flops, since the controller runs on its own clock.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1 <= 39'h0;
      pin_s2 <= 39'h0;
      ck_prev <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      ck_prev <= ck_s;
    end
  end

  // Command decode from the four strobes, chip select first.
  function automatic ddr_mode_pkg::cmd_t decode_cmd(input logic [3:0] pins);
    unique case (pins)
      4'h0: decode_cmd = ddr_mode_pkg::CMD_LOAD;
      4'h1: decode_cmd = ddr_mode_pkg::CMD_REFRESH;
      4'h2: decode_cmd = ddr_mode_pkg::CMD_PRECHARGE;
      4'h3: decode_cmd = ddr_mode_pkg::CMD_ACTIVATE;
      4'h4: decode_cmd = ddr_mode_pkg::CMD_WRITE;
      4'h5: decode_cmd = ddr_mode_pkg::CMD_READ;
      default: decode_cmd = ddr_mode_pkg::CMD_NONE;
    endcase
  endfunction

  // Commands count only with clock enable high on the previous rising edge.
  assign cmd = cke_prev ? decode_cmd(strobes_s) : ddr_mode_pkg::CMD_NONE;
  assign issue = ck_rise && (cmd != ddr_mode_pkg::CMD_NONE);
  assign accept = issue && (busy == 2'h0);
  assign in_load = issue && (busy != 2'h0);
  assign is_load_mode = accept && (cmd == ddr_mode_pkg::CMD_LOAD) && (ba_s == 2'h0);
  assign is_load_ext = accept && (cmd == ddr_mode_pkg::CMD_LOAD) && (ba_s == 2'h1);
  assign bl_legal = (a_s[2:0] >= `BL_CODE_2) && (a_s[2:0] <= `BL_CODE_8);
  assign start_burst = accept && (cmd == ddr_mode_pkg::CMD_READ || cmd == ddr_mode_pkg::CMD_WRITE);
  assign close_one = ((cmd == ddr_mode_pkg::CMD_PRECHARGE) && !a_s[`F_AP]) ||
                     (start_burst && a_s[`F_AP]);
  assign refresh_ok = accept && (cmd == ddr_mode_pkg::CMD_REFRESH) && cke_s &&
                      (open_banks == 4'h0);
  assign dll_en = !ext_reg[`F_EXT_DLL_DIS];
  assign dll_locked = (lock_cnt == `DLL_LOCK_CK);

  // Bank state; auto-precharge closes the bank at once, the controller keeps the spacing.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      open_banks <= 4'h0;
      cke_prev <= 1'b0;
      cke_seen <= 1'b0;
    end else begin
      cke_seen <= cke_seen | cke_s;
      if (ck_rise) begin
        cke_prev <= cke_s;
      end
      if (accept && cmd == ddr_mode_pkg::CMD_ACTIVATE) begin
        open_banks[ba_s] <= 1'b1;
      end else if (accept && cmd == ddr_mode_pkg::CMD_PRECHARGE && a_s[`F_AP]) begin
        open_banks <= 4'h0;
      end else if (accept && close_one) begin
        open_banks[ba_s] <= 1'b0;
      end
    end
  end

  // Mode loads take the whole address bus; a reserved length code keeps the old length.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= `MODE_RST;
      ext_reg <= `EXT_RST;
      busy <= 2'h0;
    end else begin
      if (is_load_mode) begin
        mode_reg <= {a_s[12:3], bl_legal ? a_s[2:0] : mode_reg[2:0]};
      end
      if (is_load_ext) begin
        ext_reg <= a_s;
      end
      if (accept && cmd == ddr_mode_pkg::CMD_LOAD) begin
        busy <= `LOAD_GAP_CK;
      end else if (ck_rise && busy != 2'h0) begin
        busy <= busy - 2'h1;
      end
    end
  end

  // Sticky errors: a hardware set in the clearing cycle wins over the clear.
  assign next_load_err = in_load | (load_err & ~st_clr[0]);
  assign next_bl_err = (is_load_mode && !bl_legal) | (bl_err & ~st_clr[1]);

  // Initialisation progress: DLL lock count, refresh count and ready flag.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      load_err <= 1'b0;
      bl_err <= 1'b0;
      lock_cnt <= 8'h00;
      ref_cnt <= 2'h0;
      ready <= 1'b0;
    end else begin
      load_err <= next_load_err;
      bl_err <= next_bl_err;
      if (is_load_mode && a_s[`F_DLL_RST]) begin
        lock_cnt <= 8'h00;
        ref_cnt <= 2'h0;
        ready <= 1'b0;
      end else begin
        if (ck_rise && dll_en && !dll_locked) begin
          lock_cnt <= lock_cnt + 8'h01;
        end
        if (refresh_ok && ref_cnt != 2'h3) begin
          ref_cnt <= ref_cnt + 2'h1;
        end
        if (is_load_mode && ref_cnt >= `REFRESH_MIN) begin
          ready <= 1'b1;
        end
      end
    end
  end

  // Burst geometry from the mode register; one length for reads and writes.
  assign bif.start = start_col;
  assign bif.beat = beat;
  assign bif.interleave = mode_reg[`F_BT];
  assign bif.bl = (mode_reg[2:0] == `BL_CODE_8) ? ddr_mode_pkg::BL_EIGHT :
                  (mode_reg[2:0] == `BL_CODE_4) ? ddr_mode_pkg::BL_FOUR : ddr_mode_pkg::BL_TWO;
  assign last_beat = {bif.bl == ddr_mode_pkg::BL_EIGHT, bif.bl != ddr_mode_pkg::BL_TWO, 1'b1};
  assign lat_sel = (mode_reg[6:4] == `CL_CODE_3) ? `CL3_HALF :
                   (mode_reg[6:4] == `CL_CODE_25) ? `CL25_HALF : `CL2_HALF;
  assign idx = {bank_r, bif.col[3:0]};

  ddr_burst_order u_order (
    .bif(bif.gen)
  );

  // Data beats fall on both clock edges once the half-cycle countdown ends.
  assign emit = edge_any && (phase != ddr_mode_pkg::PH_IDLE) && (hold_cnt == 3'h1);
  assign rd_emit = emit && (phase == ddr_mode_pkg::PH_READ);
  assign wr_emit = emit && (phase == ddr_mode_pkg::PH_WRITE);

  // Byte write strobes; the narrow configuration lets the lower mask gate both bytes.
  assign we_lo = wr_emit && !dm_s[0];
  assign we_hi = wr_emit && (wide16 ? !dm_s[1] : !dm_s[0]);

  // Burst sequencer; a new read or write at a rising edge cuts the running burst short.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase <= ddr_mode_pkg::PH_IDLE;
      hold_cnt <= 3'h0;
      lat_r <= 3'h0;
      beat <= 3'h0;
      start_col <= 10'h000;
      bank_r <= 2'h0;
      edge_cnt <= 3'h0;
    end else if (start_burst) begin
      phase <= (cmd == ddr_mode_pkg::CMD_READ) ? ddr_mode_pkg::PH_READ : ddr_mode_pkg::PH_WRITE;
      hold_cnt <= (cmd == ddr_mode_pkg::CMD_READ) ? lat_sel : `WR_LAT_HALF;
      lat_r <= lat_sel;
      beat <= 3'h0;
      start_col <= a_s[9:0];
      bank_r <= ba_s;
      edge_cnt <= 3'h0;
    end else if (edge_any) begin
      edge_cnt <= (edge_cnt == 3'h7) ? edge_cnt : edge_cnt + 3'h1;
      if (phase != ddr_mode_pkg::PH_IDLE && hold_cnt != 3'h1) begin
        hold_cnt <= hold_cnt - 3'h1;
      end else if (emit) begin
        beat <= beat + 3'h1;
        if (beat == last_beat) begin
          phase <= ddr_mode_pkg::PH_IDLE;
        end
      end
    end
  end

  // Storage array; masked bytes keep their old contents.
  always_ff @(posedge CLK) begin
    if (we_lo) begin
      mem[idx][7:0] <= dq_s[7:0];
    end
    if (we_hi) begin
      mem[idx][15:8] <= dq_s[15:8];
    end
  end

  // Read drivers stay off from reset until a read beat; the mask is never consulted here.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DQ_OUT <= 16'h0000;
      DQ_OE <= 16'h0000;
      DQS_OUT <= 2'h0;
      DQS_OE <= 2'h0;
    end else if (rd_emit) begin
      DQ_OUT <= mem[idx];
      DQ_OE <= 16'hFFFF;
      DQS_OUT <= {2{ck_s}};
      DQS_OE <= 2'h3;
    end else if (edge_any || !cke_s) begin
      DQ_OE <= 16'h0000;
      DQS_OE <= 2'h0;
      DQS_OUT <= 2'h0;
    end
  end

  // Register bus: one wait cycle, then the answer; writes act at the accepting edge.
  assign bus_take = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign st_clr = (bus_take && AVS_WRITE && AVS_ADDRESS == `REG_STATUS && AVS_BYTEENABLE[1]) ?
                  AVS_WRITEDATA[`ST_BL_ERR:`ST_LOAD_ERR] : 2'h0;
  assign status_word = {21'h0, bl_err, load_err, ready, ref_cnt, dll_locked, dll_en, open_banks};
  assign rd_mux = (AVS_ADDRESS == `REG_CONFIG) ? {31'h0, wide16} :
                  (AVS_ADDRESS == `REG_MODE) ? {19'h0, mode_reg} :
                  (AVS_ADDRESS == `REG_EXT) ? {19'h0, ext_reg} :
                  (AVS_ADDRESS == `REG_STATUS) ? status_word : 32'h0;

  // The wait flag doubles as the answer strobe, so its timing is fixed at one cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
      wide16 <= `CFG_WIDE16_RST;
    end else if (!AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b1;
      if (AVS_WRITE && AVS_ADDRESS == `REG_CONFIG && AVS_BYTEENABLE[0]) begin
        wide16 <= AVS_WRITEDATA[0];
      end
    end else if (AVS_READ || AVS_WRITE) begin
      AVS_WAITREQUEST <= 1'b0;
      AVS_READDATA <= AVS_READ ? rd_mux : AVS_READDATA;
    end
  end

  // Checks on the device behaviour, all in the system clock domain.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_load_mode;
    is_load_mode && bl_legal;
  endsequence

  sequence s_load_ext;
    is_load_ext;
  endsequence

  sequence s_read_start;
    start_burst && (cmd == ddr_mode_pkg::CMD_READ);
  endsequence

  AST_PRE_ALL: assert property (accept && cmd == ddr_mode_pkg::CMD_PRECHARGE && a_s[`F_AP]
    |=> open_banks == 4'h0)
    else $error("Precharge with A10 high left a bank open.");

  AST_MODE_LOAD: assert property (s_load_mode |=> mode_reg == $past(a_s))
    else $error("Mode register did not take the address operand.");

  AST_EXT_LOAD: assert property (s_load_ext |=> ext_reg == $past(a_s) && $stable(mode_reg))
    else $error("Extended mode load went to the wrong register.");

  AST_LOAD_HOLD: assert property (in_load |=> $stable(mode_reg) && $stable(ext_reg) && load_err)
    else $error("Command inside a mode load was not refused.");

  AST_BL_LEGAL: assert property (mode_reg[2:0] >= `BL_CODE_2 && mode_reg[2:0] <= `BL_CODE_8)
    else $error("Burst length field holds a reserved code.");

  AST_DQ_HIZ: assert property (!cke_seen |-> DQ_OE == 16'h0000 && DQS_OE == 2'h0)
    else $error("Outputs driven before clock enable ever rose.");

  AST_MASK_BYTES: assert property (wr_emit && wide16 && dm_s == 2'h1 |-> we_hi && !we_lo)
    else $error("Byte masks did not gate their own bytes.");

  AST_MASK_NARROW: assert property (wr_emit && !wide16 && dm_s[0] |-> !we_hi && !we_lo)
    else $error("Masked beat was written.");

  AST_BURST_BLOCK: assert property (phase != ddr_mode_pkg::PH_IDLE
    |-> bif.col[9:3] == bif.start[9:3] &&
        (bif.bl != ddr_mode_pkg::BL_TWO || bif.col[9:1] == bif.start[9:1]))
    else $error("Burst left its aligned column block.");

  AST_INTERLEAVE: assert property (bif.interleave && bif.bl == ddr_mode_pkg::BL_EIGHT
    |-> bif.col[2:0] == (bif.start[2:0] ^ bif.beat))
    else $error("Interleaved order is wrong.");

  AST_SEQUENTIAL: assert property (!bif.interleave && bif.bl == ddr_mode_pkg::BL_FOUR
    |-> bif.col[1:0] == bif.start[1:0] + bif.beat[1:0])
    else $error("Sequential order is wrong.");

  AST_BURST_TYPE: assert property (s_read_start ##1 phase == ddr_mode_pkg::PH_READ
    |-> bif.interleave == mode_reg[`F_BT])
    else $error("Burst type not taken from bit A3.");

  AST_READ_LAT: assert property (rd_emit && beat == 3'h0 |-> edge_cnt == lat_r - 3'h1)
    else $error("First read beat not at the programmed latency.");

  AST_BURST_END: assert property (emit && beat == last_beat && !start_burst
    |=> phase == ddr_mode_pkg::PH_IDLE)
    else $error("Burst ran past the programmed length.");

endmodule
`default_nettype wire

// >>> verification/ddr_ctrl_model.sv
// Memory controller model: free-running memory clock, command pins and write beats.
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
  // System clock.
  input wire logic CLK,
  // Memory clock and command pins.
  output logic CK,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [1:0] BA,
  output logic [12:0] A,
  // Write mask and data.
  output logic [1:0] DM,
  output logic [15:0] DQ_IN
);
  // A 3 ns offset keeps memory clock edges away from system clock edges.
  initial begin
    {CS_N, RAS_N, CAS_N, WE_N} = 4'hF;
    BA = 2'h0;
    A = 13'h0000;
    DM = 2'h0;
    DQ_IN = 16'h0000;
    CK = 1'b0;
    #3;
    forever #32 CK = ~CK;
  end

  // Waits for a memory clock edge and lets the block detect it before pins change.
  task automatic slot();
    @(CK);
    repeat (4) @(posedge CLK);
  endtask

  // Drives one command for the next rising memory clock edge, then deselects.
  task automatic cmd(input logic [3:0] k, input logic [1:0] b, input logic [12:0] ad);
    @(negedge CK);
    repeat (4) @(posedge CLK);
    {CS_N, RAS_N, CAS_N, WE_N} <= k;
    BA <= b;
    A <= ad;
    slot();
    {CS_N, RAS_N, CAS_N, WE_N} <= 4'hF;
    BA <= ~b; // Released lines show the inverse, so a stale value cannot pass.
    A <= ~ad;
  endtask

  // Sends n write beats, one per memory clock edge, from the edge after the command.
  task automatic wr(input int n, input logic [15:0] d[8], input logic [1:0] m[8]);
    for (int k = 0; k < n; k++) begin
      slot();
      DQ_IN <= d[k];
      DM <= m[k];
    end
    slot();
    DQ_IN <= ~d[n-1];
    DM <= ~m[n-1];
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the DDR SDRAM command, mode and burst block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [3:0] LOAD = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
  localparam logic [3:0] WR = 4'h4, RD = 4'h5, DES = 4'h8;
  logic CLK, RST_N, CK, CKE, CS_N, RAS_N, CAS_N, WE_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [1:0] BA, DM, DQS_OUT, DQS_OE;
  logic [12:0] A, md;
  logic [15:0] DQ_IN, DQ_OUT, DQ_OE;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [15:0] mem[16], d[8];
  logic [1:0] m[8];
  int bln[6] = '{2, 2, 4, 4, 8, 8};
  int clc[6] = '{2, 6, 3, 2, 6, 3};
  int hv[6] = '{4, 5, 6, 4, 5, 6};
  int st[6] = '{13, 6, 11, 5, 14, 9};
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  ddr_sdram_init_mode_burst i_ddr_sdram_init_mode_burst (.CLK, .RST_N, .CK, .CKE, .CS_N,
    .RAS_N, .CAS_N, .WE_N, .BA, .A, .DM, .DQ_IN, .DQ_OUT, .DQ_OE, .DQS_OUT, .DQS_OE,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
    .AVS_WAITREQUEST);
  ddr_ctrl_model i_ddr_ctrl_model (.CLK, .CK, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .A, .DM,
    .DQ_IN);

  // System clock.
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // A run far longer than the tests need counts as a failure.
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] wd,
                     input logic [3:0] be);
    @(posedge CLK);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= wd;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    do
      @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0, 4'hF);
    chk(rd, e);
  endtask

  task automatic issue(input logic [3:0] k, input logic [1:0] b, input logic [12:0] ad);
    i_ddr_ctrl_model.cmd(k, b, ad);
  endtask

  // Reads one burst from bank 1 and compares every beat with the expected column order.
  task automatic rdb(input int bl, input int il, input int h, input int s);
    int c;
    issue(RD, 2'h1, 13'(s));
    repeat (h) @(CK);
    for (int k = 0; k <= bl; k++) begin
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      c = (s & ~(bl - 1)) | ((il != 0 ? s ^ k : s + k) & (bl - 1));
      if (k < bl) begin
        chk(DQ_OUT, mem[c]);
        chk({DQS_OE, DQ_OE}, 18'h3FFFF);
      end else begin
        chk(DQ_OE, 16'h0);
      end
    end
  endtask

  // Main sequence; the mask input stays high through every read.
  initial begin
    RST_N = 1'b0;
    CKE = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'hF;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    chk({DQS_OE, DQ_OE}, 18'h0);
    rc(4'h0, 32'h1);
    rc(4'h8, 32'h1);
    bus(1'b1, 4'h4, 32'h1FFF, 4'hF);
    rc(4'h4, 32'h21);
    rc(4'hC, 32'h0);
    rc(4'h2, 32'h0);
    $display("test reset done");
    repeat (8) i_ddr_ctrl_model.slot(); // Shortened start wait; the block does not time it.
    CKE <= 1'b1;
    issue(DES, 2'h0, 13'h0000);
    issue(PRE, 2'h2, 13'h0400);
    issue(DES, 2'h0, 13'h0000);
    issue(LOAD, 2'h1, 13'h0000);
    issue(DES, 2'h0, 13'h0000);
    issue(LOAD, 2'h0, 13'h0123);
    issue(DES, 2'h0, 13'h0000);
    repeat (210) @(posedge CK);
    issue(PRE, 2'h0, 13'h0400);
    issue(REF, 2'h0, 13'h0000);
    issue(REF, 2'h0, 13'h0000);
    issue(LOAD, 2'h0, 13'h0023);
    issue(DES, 2'h0, 13'h0000);
    rc(4'h8, 32'h0);
    rc(4'h4, 32'h23);
    rc(4'hC, 32'h1B0);
    $display("test init done");
    issue(ACT, 2'h1, 13'h0000);
    for (int b = 0; b < 16; b += 8) begin
      for (int k = 0; k < 8; k++) begin
        mem[b + k] = {8'hA5, 4'h0, 4'(b + k)};
        d[k] = mem[b + k];
        m[k] = 2'h0;
      end
      issue(WR, 2'h1, 13'(b));
      i_ddr_ctrl_model.wr(8, d, m);
    end
    // Masked rewrite of columns 0 to 7; the final beat is unmasked, so DM rests high.
    for (int k = 0; k < 8; k++) begin
      d[k] = ~mem[k];
      m[k] = 2'((k + 1) % 4);
      mem[k] = {m[k][1] ? mem[k][15:8] : d[k][15:8], m[k][0] ? mem[k][7:0] : d[k][7:0]};
    end
    issue(WR, 2'h1, 13'h0000);
    i_ddr_ctrl_model.wr(8, d, m);
    for (int i = 0; i < 6; i++) begin
      md = {6'h0, 3'(clc[i]), 1'(i % 2), 3'(bln[i] / 4 + 1)};
      issue(PRE, 2'h0, 13'h0400);
      issue(DES, 2'h0, 13'h0000);
      issue(LOAD, 2'h0, md);
      issue(DES, 2'h0, 13'h0000);
      rc(4'h4, {19'h0, md});
      issue(ACT, 2'h1, 13'h0000);
      rdb(bln[i], i % 2, hv[i], st[i]);
    end
    $display("test bursts done");
    issue(PRE, 2'h0, 13'h0400);
    issue(LOAD, 2'h0, 13'h0027); // Reserved length code.
    issue(ACT, 2'h2, 13'h0000);
    rc(4'hC, 32'h7B0);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    chk(rd & 32'h7, 32'h3);
    bus(1'b1, 4'hC, 32'h600, 4'h2);
    rc(4'hC, 32'h1B0);
    $display("test refusal done");
    issue(ACT, 2'h0, 13'h0000);
    issue(ACT, 2'h2, 13'h0000);
    rc(4'hC, 32'h1B5);
    issue(PRE, 2'h0, 13'h0000);
    rc(4'hC, 32'h1B4);
    issue(PRE, 2'h1, 13'h0400);
    rc(4'hC, 32'h1B0);
    bus(1'b1, 4'h0, 32'h0, 4'hE);
    rc(4'h0, 32'h1);
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    rc(4'h0, 32'h0);
    $display("test precharge and config done");
    // Auto-precharge closes the bank; the controller then keeps the bank quiet long enough.
    issue(ACT, 2'h1, 13'h0000);
    rc(4'hC, 32'h1B2);
    issue(RD, 2'h1, 13'h0400);
    repeat (6) @(posedge CK); // BL/2 plus precharge time, in memory clocks.
    rc(4'hC, 32'h1B0);
    issue(ACT, 2'h1, 13'h0000);
    issue(WR, 2'h1, 13'h0400);
    i_ddr_ctrl_model.wr(8, d, m);
    repeat (8) @(posedge CK); // BL/2 plus one, write recovery and precharge time.
    rc(4'hC, 32'h1B0);
    $display("test auto-precharge done");
    wrap_up();
  end
endmodule
`default_nettype wire
